// ===== e1_tx_pkg.sv
// constants for the e1 transmit encoder and pulse shaper
// assumes a 200 MHz register clock and a 2.048 MHz framer clock
package e1_tx_pkg;
  // timing
  localparam int unsigned CLK_PS            = 5000;
  localparam int unsigned TX_CLK_KHZ        = 2048;
  localparam int unsigned UI_PS             = 1000000000 / TX_CLK_KHZ;
  localparam int unsigned SUBPHASES         = 16;
  localparam int unsigned SUB_CYCLES_RAW    = UI_PS / (SUBPHASES * CLK_PS);
  localparam int unsigned SUB_CYCLES        = (SUB_CYCLES_RAW < 1) ? 1 : SUB_CYCLES_RAW;
  localparam int unsigned LOSS_LIMIT_CYCLES = 70;
  localparam int unsigned UI_COUNT          = 4;
  // register word indices, byte address is index times four
  localparam logic [7:0] IDX_TX_CONFIG_ZERO       = 8'h04;
  localparam logic [7:0] IDX_TX_CONFIG_ONE        = 8'h05;
  localparam logic [7:0] IDX_TX_AMPLITUDE_SCALE   = 8'h06;
  localparam logic [7:0] IDX_WAVE_RAM_CONTROL     = 8'h07;
  localparam logic [7:0] IDX_WAVE_RAM_DATA        = 8'h08;
  localparam logic [7:0] IDX_INTERRUPT_MASK_ONE   = 8'h14;
  localparam logic [7:0] IDX_INTERRUPT_STATUS_ONE = 8'h19;
  // tx_config_zero fields
  localparam int unsigned CFG0_LINE_MODE_BIT = 0;
  localparam int unsigned CFG0_RAIL_BIT      = 1;
  localparam int unsigned CFG0_EDGE_BIT      = 2;
  localparam int unsigned CFG0_INVERT_BIT    = 3;
  // wave_ram_control fields
  localparam int unsigned CTRL_ADDR_W  = 6;
  localparam int unsigned CTRL_RW_BIT  = 6;
  localparam int unsigned CTRL_DONE_BIT = 7;
  // interrupt bits
  localparam int unsigned INT_CLK_LOSS_BIT = 0;
  localparam int unsigned INT_OVERFLOW_BIT = 1;
  // amplitude scaling, gain = scale * SCALE_MUL / 2**SCALE_SHIFT
  localparam logic [5:0] SCALE_RESET = 6'h21;
  localparam int unsigned SCALE_MUL   = 31;
  localparam int unsigned SCALE_SHIFT = 10;
  localparam int unsigned MAG_MAX     = 63;
  // pulse select codes
  localparam logic [3:0] PULSE_SELECT_75  = 4'h0;
  localparam logic [3:0] PULSE_SELECT_120 = 4'h1;
  localparam logic [1:0] PULSE_SELECT_ARB = 2'h3;
  // preset templates
  localparam logic [6:0] TPL75_EDGE  = 7'h0C;
  localparam logic [6:0] TPL75_FLAT  = 7'h30;
  localparam logic [6:0] TPL120_EDGE = 7'h0F;
  localparam logic [6:0] TPL120_FLAT = 7'h3C;
  localparam logic [3:0] TPL_EDGE_IDX   = 4'h3;
  localparam logic [3:0] TPL_FLAT_FIRST = 4'h4;
  localparam logic [3:0] TPL_FLAT_LAST  = 4'hB;
  // line symbols {positive, negative}
  localparam logic [1:0] SYM_SPACE = 2'h0;
  localparam logic [1:0] SYM_NEG   = 2'h1;
  localparam logic [1:0] SYM_POS   = 2'h2;
endpackage

// ===== e1_transmit_encoder_shaper.sv
// e1 transmit channel: data sampling, hdb3/ami encoding, pulse shaping, ahb-lite registers
// assumes framer clock and data arrive asynchronously; pin straps are quasi-static
`timescale 1ns/1ps
module e1_transmit_encoder_shaper #(
  parameter int unsigned LOSS_LIMIT = e1_tx_pkg::LOSS_LIMIT_CYCLES,
  parameter int unsigned SUB_CYCLES = e1_tx_pkg::SUB_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // framer side
  input  wire logic        tx_clock_in,
  input  wire logic        tx_data_pos_rail,
  input  wire logic        tx_data_neg_rail,
  // control straps
  input  wire logic        sw_control_mode,
  input  wire logic [1:0]  path_mode_pins,
  input  wire logic [3:0]  pulse_select_pins,
  // line side
  output logic [1:0]       tx_line_outputs,
  output logic [6:0]       dac_sample,
  output logic             irq
);
  localparam int unsigned PIN_W  = 10;
  localparam int unsigned LOSS_W = $clog2(LOSS_LIMIT + 2);
  localparam int unsigned SUB_W  = $clog2(SUB_CYCLES + 1);
  localparam int unsigned UIS    = e1_tx_pkg::UI_COUNT;

  // pin synchronisers
  logic [PIN_W-1:0] pin_async;
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic             clk_s;
  logic             pos_s;
  logic             neg_s;
  logic             sw_s;
  logic [1:0]       path_s;
  logic [3:0]       psel_pins_s;
  logic             clk_prev_reg;

  assign pin_async = {tx_clock_in, tx_data_pos_rail, tx_data_neg_rail, sw_control_mode,
                      path_mode_pins, pulse_select_pins};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      clk_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= pin_async;
      pin_sync_reg <= pin_meta_reg;
      clk_prev_reg <= clk_s;
    end
  end

  assign clk_s       = pin_sync_reg[9];
  assign pos_s       = pin_sync_reg[8];
  assign neg_s       = pin_sync_reg[7];
  assign sw_s        = pin_sync_reg[6];
  assign path_s      = pin_sync_reg[5:4];
  assign psel_pins_s = pin_sync_reg[3:0];

  // registers
  logic [7:0] cfg0_reg;
  logic [7:0] cfg1_reg;
  logic [5:0] scale_reg;
  logic [7:0] ctrl_reg;
  logic [6:0] wdata_reg;
  logic [7:0] mask_reg;
  logic [1:0] status_reg;

  // effective configuration
  logic       rail_dual;
  logic       ami_mode;
  logic       edge_rise;
  logic       invert;
  logic [3:0] psel;
  logic       arb_mode;

  assign rail_dual = sw_s ? cfg0_reg[e1_tx_pkg::CFG0_RAIL_BIT] : path_s[1];
  assign ami_mode  = sw_s ? cfg0_reg[e1_tx_pkg::CFG0_LINE_MODE_BIT] : path_s[0];
  assign edge_rise = sw_s & cfg0_reg[e1_tx_pkg::CFG0_EDGE_BIT];
  assign invert    = sw_s & cfg0_reg[e1_tx_pkg::CFG0_INVERT_BIT];
  assign psel      = sw_s ? cfg1_reg[3:0] : psel_pins_s;
  assign arb_mode  = (psel[3:2] == e1_tx_pkg::PULSE_SELECT_ARB);

  // clock edges and data sampling
  logic clk_rise;
  logic clk_fall;
  logic any_edge;
  logic sample_strobe;
  logic data_p;
  logic data_n;

  assign clk_rise      = clk_s & ~clk_prev_reg;
  assign clk_fall      = ~clk_s & clk_prev_reg;
  assign any_edge      = clk_rise | clk_fall;
  assign sample_strobe = edge_rise ? clk_rise : clk_fall;
  assign data_p        = pos_s ^ invert;
  assign data_n        = neg_s ^ invert;

  // transmit clock loss
  logic [LOSS_W-1:0] loss_cnt_reg;
  logic              loss_event;

  assign loss_event = (loss_cnt_reg == LOSS_W'(LOSS_LIMIT)) & ~any_edge;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      loss_cnt_reg <= '0;
    else if (any_edge)
      loss_cnt_reg <= '0;
    else if (loss_cnt_reg != LOSS_W'(LOSS_LIMIT + 1))
      loss_cnt_reg <= loss_cnt_reg + 1'b1;
  end

  // hdb3 / ami encoder, four interval look-ahead
  logic [3:0] mark_reg;
  logic [3:0] viol_reg;
  logic       parity_reg;
  logic       last_pol_reg;
  logic       zero_run;
  logic [1:0] enc_sym;
  logic [1:0] sym_next;

  assign zero_run = ~data_p & ~ami_mode & (mark_reg[2:0] == 3'h0) & (viol_reg[2:0] == 3'h0);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mark_reg   <= '0;
      viol_reg   <= '0;
      parity_reg <= 1'b0;
    end
    else if (sample_strobe && !rail_dual)
    begin
      mark_reg <= {mark_reg[2:0], data_p};
      viol_reg <= {viol_reg[2:0], zero_run};
      if (zero_run)
      begin
        parity_reg <= 1'b0;
        if (!parity_reg)
          mark_reg[3] <= 1'b1;
      end
      else if (data_p)
        parity_reg <= ~parity_reg;
    end
  end

  always_comb
  begin
    if (viol_reg[3])
      enc_sym = last_pol_reg ? e1_tx_pkg::SYM_POS : e1_tx_pkg::SYM_NEG;
    else if (mark_reg[3])
      enc_sym = last_pol_reg ? e1_tx_pkg::SYM_NEG : e1_tx_pkg::SYM_POS;
    else
      enc_sym = e1_tx_pkg::SYM_SPACE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      last_pol_reg <= 1'b0;
    else if (sample_strobe && !rail_dual && mark_reg[3] && !viol_reg[3])
      last_pol_reg <= ~last_pol_reg;
  end

  assign sym_next = rail_dual ? {data_n & ~data_p, data_p & ~data_n} : enc_sym;

  // symbol history and sub-phase timing
  logic [1:0]       sym_hist_reg [UIS];
  logic [SUB_W-1:0] sub_cnt_reg;
  logic [3:0]       sub_idx_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < UIS; i++)
        sym_hist_reg[i] <= e1_tx_pkg::SYM_SPACE;
      tx_line_outputs <= e1_tx_pkg::SYM_SPACE;
    end
    else if (sample_strobe)
    begin
      sym_hist_reg[0] <= sym_next;
      for (int i = 1; i < UIS; i++)
        sym_hist_reg[i] <= sym_hist_reg[i-1];
      tx_line_outputs <= sym_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sub_cnt_reg <= '0;
      sub_idx_reg <= '0;
    end
    else if (sample_strobe)
    begin
      sub_cnt_reg <= '0;
      sub_idx_reg <= '0;
    end
    else if (sub_cnt_reg == SUB_W'(SUB_CYCLES - 1))
    begin
      sub_cnt_reg <= '0;
      if (sub_idx_reg != 4'hF)
        sub_idx_reg <= sub_idx_reg + 1'b1;
    end
    else
      sub_cnt_reg <= sub_cnt_reg + 1'b1;
  end

  // waveform memory and preset templates
  logic [6:0] wave_ram [2**e1_tx_pkg::CTRL_ADDR_W];

  function automatic logic [6:0] rom_sample(input logic [3:0] sel, input logic [3:0] idx);
    logic is120;
    is120 = (sel == e1_tx_pkg::PULSE_SELECT_120);
    if (idx == e1_tx_pkg::TPL_EDGE_IDX)
      rom_sample = is120 ? e1_tx_pkg::TPL120_EDGE : e1_tx_pkg::TPL75_EDGE;
    else if (idx >= e1_tx_pkg::TPL_FLAT_FIRST && idx <= e1_tx_pkg::TPL_FLAT_LAST)
      rom_sample = is120 ? e1_tx_pkg::TPL120_FLAT : e1_tx_pkg::TPL75_FLAT;
    else
      rom_sample = 7'h00;
  endfunction

  function automatic logic signed [8:0] contrib(input logic [6:0] w, input logic [1:0] sym);
    logic signed [8:0] mag;
    mag = $signed({3'b000, w[5:0]});
    if (w[6])
      mag = -mag;
    if (sym == e1_tx_pkg::SYM_POS)
      contrib = mag;
    else if (sym == e1_tx_pkg::SYM_NEG)
      contrib = -mag;
    else
      contrib = '0;
  endfunction

  logic [6:0]        ui_word    [UIS];
  logic signed [8:0] ui_contrib [UIS];

  for (genvar k = 0; k < UIS; k++)
  begin : g_ui
    if (k == 0)
    begin : g_first
      assign ui_word[k] = arb_mode ? wave_ram[{2'(k), sub_idx_reg}]
                                   : rom_sample(psel, sub_idx_reg);
    end
    else
    begin : g_rest
      assign ui_word[k] = arb_mode ? wave_ram[{2'(k), sub_idx_reg}] : 7'h00;
    end
    assign ui_contrib[k] = contrib(ui_word[k], sym_hist_reg[k]);
  end

  // summing, scaling and saturation
  logic signed [8:0]  wave_sum;
  logic signed [22:0] scaled;
  logic signed [22:0] limited;
  logic               ovf_now;
  logic [6:0]         dac_next;

  assign wave_sum = ui_contrib[0] + ui_contrib[1] + ui_contrib[2] + ui_contrib[3];

  always_comb
  begin
    if (arb_mode)
      scaled = (23'(wave_sum) * $signed({1'b0, scale_reg}) * $signed(7'(e1_tx_pkg::SCALE_MUL)))
               >>> e1_tx_pkg::SCALE_SHIFT;
    else
      scaled = 23'(wave_sum);
    ovf_now = 1'b0;
    limited = scaled;
    if (scaled > $signed(23'(e1_tx_pkg::MAG_MAX)))
    begin
      limited = $signed(23'(e1_tx_pkg::MAG_MAX));
      ovf_now = 1'b1;
    end
    else if (scaled < -$signed(23'(e1_tx_pkg::MAG_MAX)))
    begin
      limited = -$signed(23'(e1_tx_pkg::MAG_MAX));
      ovf_now = 1'b1;
    end
    if (limited < 0)
      dac_next = {1'b1, 6'(-limited)};
    else
      dac_next = {1'b0, 6'(limited)};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dac_sample <= 7'h00;
    else
      dac_sample <= dac_next;
  end

  // ahb-lite slave, writes with no wait, reads with one wait state
  logic       take;
  logic       wr_pend_reg;
  logic       rd_wait_reg;
  logic [7:0] dp_idx_reg;
  logic       dp_mapped_reg;
  logic       wr_en;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic       status_read;

  assign take        = hsel & htrans[1] & hready;
  assign hreadyout   = ~rd_wait_reg;
  assign hresp       = 1'b0;
  assign wr_en       = wr_pend_reg & dp_mapped_reg;
  assign wr_byte     = hwdata[7:0];
  assign status_read = rd_wait_reg & dp_mapped_reg & (dp_idx_reg == e1_tx_pkg::IDX_INTERRUPT_STATUS_ONE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg   <= 1'b0;
      rd_wait_reg   <= 1'b0;
      dp_idx_reg    <= 8'h00;
      dp_mapped_reg <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= take & hwrite;
      rd_wait_reg <= take & ~hwrite;
      if (take)
      begin
        dp_idx_reg    <= haddr[9:2];
        dp_mapped_reg <= (haddr[31:10] == 22'h00_0000) & (haddr[1:0] == 2'h0);
      end
    end
  end

  always_comb
  begin
    if (!dp_mapped_reg)
      rd_byte = 8'h00;
    else if (dp_idx_reg == e1_tx_pkg::IDX_TX_CONFIG_ZERO)
      rd_byte = cfg0_reg;
    else if (dp_idx_reg == e1_tx_pkg::IDX_TX_CONFIG_ONE)
      rd_byte = cfg1_reg;
    else if (dp_idx_reg == e1_tx_pkg::IDX_TX_AMPLITUDE_SCALE)
      rd_byte = {2'h0, scale_reg};
    else if (dp_idx_reg == e1_tx_pkg::IDX_WAVE_RAM_CONTROL)
      rd_byte = ctrl_reg;
    else if (dp_idx_reg == e1_tx_pkg::IDX_WAVE_RAM_DATA)
      rd_byte = {1'b0, wdata_reg};
    else if (dp_idx_reg == e1_tx_pkg::IDX_INTERRUPT_MASK_ONE)
      rd_byte = mask_reg;
    else if (dp_idx_reg == e1_tx_pkg::IDX_INTERRUPT_STATUS_ONE)
      rd_byte = {6'h00, status_reg};
    else
      rd_byte = 8'h00;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_wait_reg)
      hrdata <= {24'h00_0000, rd_byte};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg0_reg  <= 8'h00;
      cfg1_reg  <= 8'h00;
      scale_reg <= e1_tx_pkg::SCALE_RESET;
      mask_reg  <= 8'h00;
    end
    else if (wr_en)
    begin
      if (dp_idx_reg == e1_tx_pkg::IDX_TX_CONFIG_ZERO)
        cfg0_reg <= wr_byte;
      else if (dp_idx_reg == e1_tx_pkg::IDX_TX_CONFIG_ONE)
        cfg1_reg <= wr_byte;
      else if (dp_idx_reg == e1_tx_pkg::IDX_TX_AMPLITUDE_SCALE)
        scale_reg <= wr_byte[5:0];
      else if (dp_idx_reg == e1_tx_pkg::IDX_INTERRUPT_MASK_ONE)
        mask_reg <= wr_byte;
    end
  end

  // waveform ram access, done stands one cycle while the access runs
  logic [5:0] ram_addr;

  assign ram_addr = ctrl_reg[e1_tx_pkg::CTRL_ADDR_W-1:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= 8'h00;
    else if (wr_en && dp_idx_reg == e1_tx_pkg::IDX_WAVE_RAM_CONTROL)
      ctrl_reg <= wr_byte;
    else if (ctrl_reg[e1_tx_pkg::CTRL_DONE_BIT])
      ctrl_reg[e1_tx_pkg::CTRL_DONE_BIT] <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdata_reg <= 7'h00;
    else if (ctrl_reg[e1_tx_pkg::CTRL_DONE_BIT] && ctrl_reg[e1_tx_pkg::CTRL_RW_BIT])
    begin
      if (arb_mode)
        wdata_reg <= wave_ram[ram_addr];
      else if (ram_addr[5:4] == 2'h0)
        wdata_reg <= rom_sample(psel, ram_addr[3:0]);
      else
        wdata_reg <= 7'h00;
    end
    else if (wr_en && dp_idx_reg == e1_tx_pkg::IDX_WAVE_RAM_DATA)
      wdata_reg <= wr_byte[6:0];
  end

  always_ff @(posedge hclk)
  begin
    if (ctrl_reg[e1_tx_pkg::CTRL_DONE_BIT] && !ctrl_reg[e1_tx_pkg::CTRL_RW_BIT])
      wave_ram[ram_addr] <= wdata_reg;
  end

  // sticky status, cleared by read, a new event wins over the clear
  logic [1:0] events;

  assign events = {ovf_now, loss_event};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_reg <= 2'h0;
      irq        <= 1'b0;
    end
    else
    begin
      status_reg <= (status_read ? 2'h0 : status_reg) | events;
      irq        <= |(status_reg & mask_reg[1:0]);
    end
  end

  // checks
  a_loss_flag_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    loss_event |=> status_reg[e1_tx_pkg::INT_CLK_LOSS_BIT] && loss_cnt_reg == LOSS_W'(LOSS_LIMIT + 1))
    else $error("clock loss not flagged after idle limit");

  a_loss_irq_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (status_reg[e1_tx_pkg::INT_CLK_LOSS_BIT] && mask_reg[e1_tx_pkg::INT_CLK_LOSS_BIT]) |=> irq)
    else $error("enabled clock loss did not raise irq");

  a_edge_select: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sample_strobe && sw_s) |-> (cfg0_reg[e1_tx_pkg::CFG0_EDGE_BIT] ? (clk_s && !clk_prev_reg)
                                                                     : (!clk_s && clk_prev_reg)))
    else $error("data sampled on wrong clock edge");

  a_pin_edge: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sample_strobe && !sw_s) |-> (!clk_s && clk_prev_reg && !invert))
    else $error("pin control did not use falling edge, active high");

  a_dual_rail_map: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sample_strobe && rail_dual && (pos_s ^ invert) && !(neg_s ^ invert))
      |=> tx_line_outputs == e1_tx_pkg::SYM_NEG)
    else $error("dual rail positive input did not give negative pulse");

  a_ram_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ctrl_reg[e1_tx_pkg::CTRL_DONE_BIT] && !ctrl_reg[e1_tx_pkg::CTRL_RW_BIT])
      |=> wave_ram[$past(ram_addr)] == $past(wdata_reg))
    else $error("waveform ram write lost");

  a_done_clears: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(ctrl_reg[e1_tx_pkg::CTRL_DONE_BIT]) |=> !ctrl_reg[e1_tx_pkg::CTRL_DONE_BIT])
    else $error("done bit did not clear after access");

  a_overflow_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ovf_now |=> status_reg[e1_tx_pkg::INT_OVERFLOW_BIT] ##1 (irq == mask_reg[e1_tx_pkg::INT_OVERFLOW_BIT]
                                                            || status_reg[e1_tx_pkg::INT_CLK_LOSS_BIT]))
    else $error("overflow not flagged or irq gating wrong");

  a_preset_unscaled: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !arb_mode |=> dac_sample[5:0] <= 6'(e1_tx_pkg::TPL120_FLAT))
    else $error("preset template amplitude was scaled");

  a_scale_reset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> scale_reg == e1_tx_pkg::SCALE_RESET)
    else $error("scale field reset value wrong");
endmodule

// ===== tx_framer_model.sv
// framer model: gated line clock, data launched on its rising edge
// assumes the bench gates the clock with run and supplies the bits
`timescale 1ns/1ps
module tx_framer_model (
  // control from bench
  input  wire logic run,
  input  wire logic pos_bit,
  input  wire logic neg_bit,
  // link to the block
  output logic      tx_clock_in,
  output logic      tx_data_pos_rail,
  output logic      tx_data_neg_rail
);
  initial
  begin
    tx_clock_in = 1'b0;
    tx_data_pos_rail = 1'b0;
    tx_data_neg_rail = 1'b0;
  end
  always #32 if (run) tx_clock_in = ~tx_clock_in;
  always @(posedge tx_clock_in)
  begin
    tx_data_pos_rail <= pos_bit;
    tx_data_neg_rail <= neg_bit;
  end
  // both lines flip once when run drops and the clock stands
  always @(negedge run)
  begin
    tx_data_pos_rail <= ~tx_data_pos_rail;
    tx_data_neg_rail <= ~tx_data_neg_rail;
  end
endmodule

// ===== tb_top.sv
// bench for the e1 transmit encoder and shaper
// assumes a framer model on the link and an ahb-lite master here
`timescale 1ns/1ps
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        run, pos_bit, neg_bit, sw_control_mode;
  logic        tx_clock_in, tx_data_pos_rail, tx_data_neg_rail;
  logic [1:0]  htrans, path_mode_pins, tx_line_outputs, a;
  logic [2:0]  hsize;
  logic [3:0]  pulse_select_pins;
  logic [6:0]  dac_sample;
  logic [5:0]  peak;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          errors, tests_run, np, nn;

  e1_transmit_encoder_shaper #(.LOSS_LIMIT(8), .SUB_CYCLES(1)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_clock_in(tx_clock_in), .tx_data_pos_rail(tx_data_pos_rail), .tx_data_neg_rail(tx_data_neg_rail),
    .sw_control_mode(sw_control_mode), .path_mode_pins(path_mode_pins),
    .pulse_select_pins(pulse_select_pins), .tx_line_outputs(tx_line_outputs),
    .dac_sample(dac_sample), .irq(irq));
  tx_framer_model i_framer (.run(run), .pos_bit(pos_bit), .neg_bit(neg_bit), .tx_clock_in(tx_clock_in),
    .tx_data_pos_rail(tx_data_pos_rail), .tx_data_neg_rail(tx_data_neg_rail));

  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) if (dac_sample[5:0] > peak) peak <= dac_sample[5:0];

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one single transfer, hready sampled at each rising edge
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask
  task automatic rdchk(input logic [31:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0000_0000);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic ui(input int n);
    repeat (n) @(posedge tx_clock_in);
  endtask
  task automatic t_regs;
    rdchk(32'h0000_0018, {26'h0, e1_tx_pkg::SCALE_RESET});
    rdchk(32'h0000_0010, 32'h0000_0000);
    wr(32'h0000_0040, 32'h0000_0055);
    rdchk(32'h0000_0040, 32'h0000_0000);
    wr(32'h0000_0018, 32'h0000_003F);
    rdchk(32'h0000_0018, 32'h0000_003F);
  endtask
  task automatic t_rail(input logic sw, input logic [1:0] pins, input logic [7:0] cfg, input logic p,
                        input logic n, input logic [1:0] exp);
    sw_control_mode <= sw;
    path_mode_pins <= pins;
    wr(32'h0000_0010, {24'h0, cfg});
    pos_bit = p;
    neg_bit = n;
    peak = 6'h00;
    ui(8);
    check({30'h0, tx_line_outputs}, {30'h0, exp});
  endtask
  task automatic t_code;
    sw_control_mode <= 1'b1;
    wr(32'h0000_0010, 32'h0000_0001);
    pos_bit = 1'b1;
    ui(8);
    a = tx_line_outputs;
    ui(1);
    check({31'h0, a[0] ^ a[1]}, 32'h0000_0001);
    check({30'h0, tx_line_outputs}, {30'h0, ~a});
    wr(32'h0000_0010, 32'h0000_0000);
    pos_bit = 1'b0;
    ui(8);
    np = 0;
    nn = 0;
    repeat (8)
    begin
      ui(1);
      np += (tx_line_outputs === e1_tx_pkg::SYM_POS);
      nn += (tx_line_outputs === e1_tx_pkg::SYM_NEG);
    end
    check(np, 2);
    check(nn, 2);
  endtask
  task automatic t_ram;
    wr(32'h0000_0010, 32'h0000_0002);
    ui(5);
    wr(32'h0000_0014, 32'h0000_000C);
    wr(32'h0000_0020, 32'h0000_0045);
    wr(32'h0000_001C, 32'h0000_0093);
    repeat (4) @(posedge hclk);
    wr(32'h0000_0020, 32'h0000_0000);
    wr(32'h0000_001C, 32'h0000_00D3);
    repeat (4) @(posedge hclk);
    rdchk(32'h0000_001C, 32'h0000_0053);
    rdchk(32'h0000_0020, 32'h0000_0045);
    wr(32'h0000_0014, 32'h0000_0001);
    wr(32'h0000_001C, 32'h0000_00C4);
    repeat (4) @(posedge hclk);
    rdchk(32'h0000_0020, {25'h0, e1_tx_pkg::TPL120_FLAT});
  endtask
  task automatic t_loss;
    wr(32'h0000_0050, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0000);
    run = 1'b0;
    repeat (20) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0001);
    rdchk(32'h0000_0064, 32'h0000_0001);
    run = 1'b1;
  endtask

  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {pos_bit, neg_bit, path_mode_pins, pulse_select_pins, peak} = '0;
    run = 1'b1;
    sw_control_mode = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_rail(1'b1, 2'h0, 8'h02, 1'b1, 1'b0, e1_tx_pkg::SYM_NEG);
    check({26'h0, peak}, {26'h0, e1_tx_pkg::TPL75_FLAT[5:0]});
    t_rail(1'b1, 2'h0, 8'h02, 1'b0, 1'b1, e1_tx_pkg::SYM_POS);
    t_rail(1'b1, 2'h0, 8'h02, 1'b1, 1'b1, e1_tx_pkg::SYM_SPACE);
    t_rail(1'b1, 2'h0, 8'h0A, 1'b1, 1'b0, e1_tx_pkg::SYM_POS);
    t_rail(1'b0, 2'h2, 8'h0C, 1'b1, 1'b0, e1_tx_pkg::SYM_NEG);
    t_code();
    t_ram();
    t_loss();
    conclude();
  end
  initial
  begin
    #100000;
    errors++;
    conclude();
  end
endmodule
